// *** bench/acr_ctrl_tb.sv ***
// Purpose: self-checking bench for the converter control register block
// Assumes: comparator modelled from a test level, settle time cut to one cycle
// Notes:   bench drives the register port and comparator itself, no partner model
`timescale 1ns/100ps
`include "acr_defines.svh"
module acr_ctrl_tb;
  localparam int SMP  = 4;
  localparam int BTK  = 4;
  localparam int CONV = SMP + 10 * BTK;

  logic        clk;
  logic        arst_n;
  logic [7:0]  bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata;
  logic        halt_mode;
  logic        cmp_in;
  logic        conv_power;
  logic [3:0]  chan_sel;
  logic        sample_hold;
  logic [9:0]  dac_trial;
  logic        irq;
  logic [10:0] vin;
  logic [7:0]  rv;
  int          bad_count;
  int          checks_done;
  int          p;
  int          div_tab [4] = '{2, 1, 4, 2};

  acr_ctrl #(
    .SETTLE_NS    (8),
    .SAMPLE_TICKS (SMP),
    .BIT_TICKS    (BTK)
  ) i_acr_ctrl (
    .clk         (clk),
    .arst_n      (arst_n),
    .bus_addr    (bus_addr),
    .bus_wdata   (bus_wdata),
    .bus_wr      (bus_wr),
    .bus_rd      (bus_rd),
    .bus_rdata   (bus_rdata),
    .halt_mode   (halt_mode),
    .cmp_in      (cmp_in),
    .conv_power  (conv_power),
    .chan_sel    (chan_sel),
    .sample_hold (sample_hold),
    .dac_trial   (dac_trial),
    .irq         (irq)
  );

  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // comparator: level seen against the trial code; an 11-bit level can exceed full scale
  always @(posedge clk) begin
    cmp_in <= (vin >= {1'b0, dac_trial});
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // poll the done flag; reading the status byte must not clear it
  task automatic wait_done();
    logic [7:0] d;
    d = 8'h00;
    for (int n = 0; n < 300 && d[7] !== 1'b1; n++) begin
      rd(`ACR_OFS_CSR, d);
    end
    chk(16'(d[7]), 16'h0001);
  endtask

  // flush old samples, clear done, then read the pair low byte first
  task automatic conv_chk(input logic [10:0] v, input logic [9:0] exp);
    vin <= v;
    repeat (200) @(posedge clk);
    wr(`ACR_OFS_CSR, 8'h23);
    wait_done();
    rdchk(`ACR_OFS_LO, {6'h00, exp[1:0]});
    rdchk(`ACR_OFS_HI, exp[9:2]);
  endtask

  // cycles up to the next rising edge of sample_hold
  task automatic rise(output int n);
    logic prev;
    prev = sample_hold;
    for (n = 1; n <= 1000; n++) begin
      @(posedge clk);
      #1;
      if (sample_hold === 1'b1 && prev === 1'b0) break;
      prev = sample_hold;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    arst_n      = 1'b0;
    bus_addr    = 8'h00;
    bus_wdata   = 8'h00;
    bus_wr      = 1'b0;
    bus_rd      = 1'b0;
    halt_mode   = 1'b0;
    cmp_in      = 1'b0;
    vin         = 11'h000;
    bad_count   = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(`ACR_OFS_CSR, 8'h00);
    rdchk(`ACR_OFS_HI, 8'h00);
    rdchk(`ACR_OFS_LO, 8'h00);
    wr(8'h50, 8'hFF);
    rdchk(8'h50, 8'h00);
    wr(`ACR_OFS_HI, 8'hFF);
    rdchk(`ACR_OFS_HI, 8'h00);
    wr(`ACR_OFS_LO, 8'hFF);
    rdchk(`ACR_OFS_LO, 8'h00);
    wr(`ACR_OFS_CSR, 8'hDF);
    rdchk(`ACR_OFS_CSR, 8'h5F);
    chk(16'(conv_power), 16'h0000);
    for (int i = 0; i < 16; i++) begin
      wr(`ACR_OFS_CSR, {4'h0, 4'(i)});
      #1;
      chk(16'(chan_sel), 16'(i));
    end
    $display("test registers done");
    conv_chk(11'h2A5, 10'h2A5);
    rdchk(`ACR_OFS_CSR, 8'h23);
    conv_chk(11'h7FF, 10'h3FF);
    conv_chk(11'h000, 10'h000);
    wait_done();
    wr(`ACR_OFS_CSR, 8'h23);
    rdchk(`ACR_OFS_CSR, 8'h23);
    $display("test conversion done");
    // low read locks; newer samples wait until the high byte is read
    conv_chk(11'h155, 10'h155);
    wait_done();
    rdchk(`ACR_OFS_LO, 8'h01);
    vin <= 11'h2AA;
    repeat (300) @(posedge clk);
    rdchk(`ACR_OFS_HI, 8'h55);
    rdchk(`ACR_OFS_HI, 8'hAA);
    rdchk(`ACR_OFS_LO, 8'h02);
    rd(`ACR_OFS_HI, rv);
    $display("test lock done");
    wait_done();
    wr(`ACR_OFS_CSR, 8'h27);
    rdchk(`ACR_OFS_CSR, 8'h27);
    chk(16'(chan_sel), 16'h0007);
    wait_done();
    $display("test channel change done");
    // third rise is measured so the new divider has fully taken over
    for (int k = 0; k < 4; k++) begin
      wr(`ACR_OFS_CSR, {1'b0, k[0], 1'b1, k[1], 4'h7});
      rise(p);
      rise(p);
      rise(p);
      chk(16'(p), 16'(CONV * div_tab[k]));
    end
    $display("test clock select done");
    halt_mode <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(conv_power), 16'h0000);
    halt_mode <= 1'b0;
    repeat (4) @(posedge clk);
    chk(16'(conv_power), 16'h0001);
    wr(`ACR_OFS_CSR, 8'h27);
    wait_done();
    $display("test halt done");
    // clearing converter-on must stop conversion and release a held lock
    rd(`ACR_OFS_LO, rv);
    wr(`ACR_OFS_CSR, 8'h07);
    repeat (3) @(posedge clk);
    chk(16'(conv_power), 16'h0000);
    chk(16'(sample_hold), 16'h0000);
    vin <= 11'h0F0;
    wr(`ACR_OFS_CSR, 8'h27);
    wait_done();
    rdchk(`ACR_OFS_HI, 8'h3C);
    $display("test power off done");
    // interrupt: masked, unmasked, then cleared with the converter stopped
    wr(8'h49, 8'h00);
    wait_done();
    chk(16'(irq), 16'h0000);
    rdchk(8'h48, 8'h01);
    wr(8'h49, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(irq), 16'h0001);
    wr(`ACR_OFS_CSR, 8'h07);
    repeat (3) @(posedge clk);
    wr(8'h48, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(irq), 16'h0000);
    rdchk(8'h48, 8'h00);
    rdchk(8'h49, 8'h01);
    $display("test interrupt done");
    tally_and_finish();
  end

  // watchdog, well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule

// *** rtl/acr_ctrl.sv ***
// Purpose: register file, clock divider, result lock and power handling of the converter
// Assumes: byte register port, halt request from the power controller on the same clock
// Notes:   wait mode is invisible here; the block just keeps running through it
`timescale 1ns/100ps
`include "acr_defines.svh"
module acr_ctrl
  import acr_pkg::*;
#(
  parameter int SETTLE_NS    = `ACR_SETTLE_NS,
  parameter int SAMPLE_TICKS = `ACR_SAMPLE_TK,
  parameter int BIT_TICKS    = `ACR_BIT_TK
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // register port
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic [7:0]      bus_rdata,
  // power management
  input  wire logic       halt_mode,
  // analog core
  input  wire logic       cmp_in,
  output logic            conv_power,
  output logic [3:0]      chan_sel,
  output logic            sample_hold,
  output logic [9:0]      dac_trial,
  // interrupt
  output logic            irq
);
  localparam int WAKE_CYC = (SETTLE_NS * `ACR_CLK_MHZ + 999) / 1000;

  if (WAKE_CYC < 1 || WAKE_CYC > 65535)
    $error("acr_ctrl: settle count out of range");

  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_sync_q <= 2'b00;
    else         rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // divide ratio minus one for slow and speed
  function automatic logic [1:0] div_ratio(input logic slow, input logic speed);
    logic [1:0] r;
    r = 2'd1;
    if (!slow && speed)      r = 2'd0;
    else if (slow && !speed) r = 2'd3;
    return r;
  endfunction

  acr_top_t   q, d;
  logic       wr_csr;
  logic       wr_ist;
  logic       wr_msk;
  logic       rd_csr;
  logic       rd_hi;
  logic       rd_lo;
  logic       rd_ist;
  logic       rd_msk;
  logic       chan_chg;
  logic       gate;
  logic       unlock_now;
  logic       lock_eff;
  logic       res_wr;
  logic [9:0] res_val;
  logic       run_core;
  logic       core_done;
  logic [9:0] core_res;

  // address decode
  always_comb begin
    wr_csr = 1'b0;
    wr_ist = 1'b0;
    wr_msk = 1'b0;
    rd_csr = 1'b0;
    rd_hi  = 1'b0;
    rd_lo  = 1'b0;
    rd_ist = 1'b0;
    rd_msk = 1'b0;
    if (bus_addr == `ACR_OFS_CSR) begin
      wr_csr = bus_wr;
      rd_csr = bus_rd;
    end else if (bus_addr == `ACR_OFS_HI) begin
      rd_hi = bus_rd;
    end else if (bus_addr == `ACR_OFS_LO) begin
      rd_lo = bus_rd;
    end else if (bus_addr == `ACR_OFS_IRQST) begin
      wr_ist = bus_wr;
      rd_ist = bus_rd;
    end else if (bus_addr == `ACR_OFS_IRQMSK) begin
      wr_msk = bus_wr;
      rd_msk = bus_rd;
    end
  end

  // channel change and power-off both kill the result in flight
  assign chan_chg   = wr_csr && (bus_wdata[3:0] != q.chan);
  assign gate       = chan_chg || q.abort || !q.on;
  assign unlock_now = q.lock && (rd_hi || !q.on);
  // a completion that lands in the very cycle of the low read must wait too,
  // or the high byte would come from a newer sample than the low byte just read
  assign lock_eff   = (q.lock && !unlock_now) || (rd_lo && q.on);
  // halt, settle and abort hold the sequencer idle
  assign run_core   = q.pwr && (q.settle == 16'h0000) && !q.abort;

  // result write: fresh when unlocked, pending one on release
  always_comb begin
    res_wr  = 1'b0;
    res_val = core_res;
    if (core_done && !gate && !lock_eff) begin
      res_wr = 1'b1;
    end else if (unlock_now && q.pend_v && q.on) begin
      res_wr  = 1'b1;
      res_val = q.pend;
    end
  end

  // next state of the whole block
  always_comb begin
    d = q;
    // control/status fields; bit 7 is never taken from the bus
    if (wr_csr) begin
      d.speed = bus_wdata[`ACR_CSR_SPEED];
      d.on    = bus_wdata[`ACR_CSR_ON];
      d.slow  = bus_wdata[`ACR_CSR_SLOW];
      d.chan  = bus_wdata[3:0];
    end
    d.abort = chan_chg;
    // done flag: clears first so that a completion wins
    if (wr_csr || rd_hi) d.eoc = 1'b0;
    if (res_wr)          d.eoc = 1'b1;
    // freeze of both result bytes
    if (rd_lo && q.on)   d.lock = 1'b1;
    else if (unlock_now) d.lock = 1'b0;
    // results and held-back sample
    if (res_wr) begin
      d.hi     = res_val[9:2];
      d.lo     = res_val[1:0];
      d.pend_v = 1'b0;
    end else if (core_done && !gate && lock_eff) begin
      d.pend   = core_res; // newest sample kept, older ones dropped
      d.pend_v = 1'b1;
    end
    if (!q.on) d.pend_v = 1'b0;
    // converter tick from the cpu clock
    if (q.div >= div_ratio(q.slow, q.speed)) begin
      d.div  = 2'd0;
      d.tick = 1'b1;
    end else begin
      d.div  = q.div + 2'd1;
      d.tick = 1'b0;
    end
    // power and wake-up settle; wait mode needs nothing here
    d.pwr = q.on && !halt_mode;
    if (halt_mode)                  d.settle = 16'(WAKE_CYC);
    else if (q.settle != 16'h0000)  d.settle = q.settle - 16'h0001;
    // interrupt status, write one to clear, set wins
    if (wr_ist && bus_wdata[0]) d.irq_st = 1'b0;
    if (res_wr)                 d.irq_st = 1'b1;
    if (wr_msk)                 d.irq_msk = bus_wdata[0];
    d.irq = q.irq_st && q.irq_msk;
    // comparator pin synchroniser
    d.cmp_s1 = cmp_in;
    d.cmp_s2 = q.cmp_s1;
    // read data valid only in the cycle after the strobe
    d.rdata = 8'h00;
    if (rd_csr)      d.rdata = {q.eoc, q.speed, q.on, q.slow, q.chan};
    else if (rd_hi)  d.rdata = q.hi;
    else if (rd_lo)  d.rdata = {6'h00, q.lo};
    else if (rd_ist) d.rdata = {7'h00, q.irq_st};
    else if (rd_msk) d.rdata = {7'h00, q.irq_msk};
  end

  // all block state, reset to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else        q <= d;
  end

  // sequencer
  acr_sar_core #(
    .SAMPLE_TICKS (SAMPLE_TICKS),
    .BIT_TICKS    (BIT_TICKS)
  ) u_core (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (run_core),
    .tick   (q.tick),
    .comp   (q.cmp_s2),
    .trial  (dac_trial),
    .sample (sample_hold),
    .done   (core_done),
    .result (core_res)
  );

  // outputs straight from flops
  assign bus_rdata  = q.rdata;
  assign conv_power = q.pwr;
  assign chan_sel   = q.chan;
  assign irq        = q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic is4;
  logic is1;
  logic is2;
  assign is4 = q.slow && !q.speed;
  assign is1 = !q.slow && q.speed;
  assign is2 = q.slow == q.speed;

  // halved clock: one idle cycle between ticks
  sequence s_div2_gap;
    q.tick && is2 ##1 (is2 && !q.tick);
  endsequence

  // a completion that arrives while the pair is frozen
  sequence s_held_done;
    core_done && !gate && lock_eff;
  endsequence

  sequence s_div4_gap;
    q.tick && is4 ##1 (is4 && !q.tick) [*3];
  endsequence

  sequence s_csr_wr_rd;
    wr_csr ##1 rd_csr;
  endsequence

  lock_on_read_a: assert property (rd_lo && q.on |=> q.lock)
    else $error("low byte read did not lock");
  freeze_hold_a: assert property (q.lock && q.on && !rd_hi |=> $stable({q.hi, q.lo}))
    else $error("result changed while locked");
  unlock_hi_a: assert property (q.lock && rd_hi |=> !q.lock)
    else $error("high byte read did not unlock");
  unlock_off_a: assert property (!q.on |=> !q.lock && !q.pend_v)
    else $error("lock held while off");
  eoc_write_a: assert property (wr_csr && !res_wr |=> !q.eoc)
    else $error("write did not clear done");
  eoc_hi_read_a: assert property (rd_hi && !res_wr |=> !q.eoc)
    else $error("high read did not clear done");
  eoc_set_a: assert property (res_wr |=> q.eoc && q.irq_st)
    else $error("done not set with result");
  csr_back_a: assert property (s_csr_wr_rd |=> bus_rdata[6:0] == $past(bus_wdata[6:0], 2))
    else $error("control readback wrong");
  div_four_a: assert property (s_div4_gap |=> q.tick)
    else $error("divide by four spacing wrong");
  div_one_a: assert property (is1 && $past(is1) |-> q.tick)
    else $error("undivided tick missing");
  halt_off_a: assert property (halt_mode |=> !q.pwr && q.settle == 16'(WAKE_CYC))
    else $error("halt did not stop converter");
  settle_idle_a: assert property (q.settle != 16'h0000 |-> !run_core)
    else $error("converting before settle");
  chan_abort_a: assert property (chan_chg |=> q.abort && !q.eoc && !run_core)
    else $error("channel change did not abort");
  rd_hi_a: assert property (rd_hi |=> bus_rdata == $past(q.hi))
    else $error("high byte read wrong");
  rd_lo_a: assert property (rd_lo |=> bus_rdata == {6'h00, $past(q.lo)})
    else $error("low byte read wrong");
  irq_level_a: assert property (q.irq_st && q.irq_msk |=> irq)
    else $error("interrupt not raised");

  // the low read itself must already shield both bytes
  lo_read_hold_a: assert property (rd_lo && q.on |=> $stable({q.hi, q.lo}))
    else $error("result changed on low read");

  // frozen completions are parked, then released by the high read
  held_park_a: assert property (s_held_done |=> q.pend_v)
    else $error("held result not parked");
  pend_release_a: assert property (unlock_now && q.pend_v && q.on |=> {q.hi, q.lo} == $past(q.pend))
    else $error("parked result not released");

  // a result written is split over the two bytes unchanged
  res_split_a: assert property (res_wr |=> {q.hi, q.lo} == $past(res_val))
    else $error("result bytes split wrong");

  // converter power follows converter-on; wait mode has no say in it
  pwr_follow_a: assert property (q.on && !halt_mode |=> conv_power)
    else $error("converter not powered");
  off_dark_a: assert property (!q.on |=> !conv_power)
    else $error("converter powered while off");

  // settle counter runs down one per cycle after wake-up
  wake_count_a: assert property (!halt_mode && q.settle != 16'h0000 |=> q.settle == $past(q.settle) - 16'h0001)
    else $error("settle count wrong");

  // channel pins follow the written field
  chan_out_a: assert property (wr_csr |=> chan_sel == $past(bus_wdata[3:0]))
    else $error("channel select wrong");

  // status bit 7 reads the done flag, never the written value
  csr_done_a: assert property (rd_csr |=> bus_rdata[7] == $past(q.eoc))
    else $error("done bit read wrong");

  // read data stand for one cycle only, then fall back to zero
  rdata_idle_a: assert property (!bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not cleared");

  // the halved clock ticks every second cycle
  div_two_a: assert property (s_div2_gap |=> q.tick)
    else $error("divide by two spacing wrong");

  // write one clears the interrupt status unless a result lands
  irq_clear_a: assert property (wr_ist && bus_wdata[0] && !res_wr |=> !q.irq_st)
    else $error("interrupt status not cleared");
endmodule

// *** rtl/acr_defines.svh ***
// Purpose: offsets, field positions, reset values and timing for the converter control block
// Assumes: byte-wide register port, single 125 MHz clock
// Notes:   included by every file of the block except the type package
// Function
// - A read of the low result byte freezes both result bytes.
// - The freeze ends on a read of the high result byte or while converter-on is clear.
// - While frozen, new results are held back and written only after the high byte read.
// - The wait low-power state has no effect on the converter or its registers.
// - Halt disables the converter; after wake-up a settle interval passes before converting.
// - The done flag in bit 7 is set on completion, cleared by a high byte read or a control/status write.
// - The control/status register is read/write except read-only bit 7, reset to zero.
// - Converter clock is cpu/2, cpu/1 (at or below 4 MHz), cpu/4 or cpu/2 by slow/speed.
// - Setting converter-on powers and starts the converter; clearing it stops conversion.
// - The 4-bit channel field selects input 0 to 15 by its binary value.
// - The high result byte is read-only, resets to zero and holds result bits 9 to 2.
// - The low result byte is read-only, resets to zero, bits 7:2 read zero, 1:0 hold bits 1:0.
// - Control/status, high and low result sit at 45h, 46h and 47h.
// - Once on, the converter converts the selected channel again and again.
// - A write that changes the channel aborts, clears done and restarts on the new input.
// - Inputs above full scale give 3FFh, below zero scale give 000h, with no overflow flag.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
`define ACR_OFS_CSR    8'h45
`define ACR_OFS_HI     8'h46
`define ACR_OFS_LO     8'h47
`define ACR_OFS_IRQST  8'h48
`define ACR_OFS_IRQMSK 8'h49
`define ACR_CSR_DONE   7
`define ACR_CSR_SPEED  6
`define ACR_CSR_ON     5
`define ACR_CSR_SLOW   4
`define ACR_CSR_RST    8'h00
`define ACR_RES_RST    10'h000
`define ACR_RES_FULL   10'h3FF
`define ACR_RES_MSB    10'h200
`define ACR_CLK_MHZ    125
`define ACR_SETTLE_NS  1000
`define ACR_SAMPLE_TK  4
`define ACR_BIT_TK     4
`define ACR_RES_BITS   10
`endif

// *** rtl/acr_pkg.sv ***
// Purpose: shared types of the converter control block
// Assumes: fixed 10-bit result
// Notes:   state structs are registered whole by each module
package acr_pkg;
  // sequencer phases, gray along idle, sample, convert
  typedef enum logic [1:0] {
    ACR_IDLE   = 2'b00,
    ACR_SAMPLE = 2'b01,
    ACR_CONV   = 2'b11
  } acr_phase_t;

  typedef struct packed {
    acr_phase_t phase;
    logic [3:0] tk;
    logic [3:0] bitn;
    logic [9:0] trial;
    logic [9:0] res;
    logic       sample;
    logic       done;
    logic       allhi;
    logic       alllo;
  } acr_core_t;

  typedef struct packed {
    logic        speed;
    logic        on;
    logic        slow;
    logic [3:0]  chan;
    logic        eoc;
    logic [7:0]  hi;
    logic [1:0]  lo;
    logic        lock;
    logic        pend_v;
    logic [9:0]  pend;
    logic [1:0]  div;
    logic        tick;
    logic        abort;
    logic [15:0] settle;
    logic        irq_st;
    logic        irq_msk;
    logic        irq;
    logic [7:0]  rdata;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        pwr;
  } acr_top_t;
endpackage

// *** rtl/acr_sar_core.sv ***
// Purpose: successive-approximation sequencer driven by converter ticks
// Assumes: comparator input already synchronised, high when input >= trial code
// Notes:   comparator sync lag needs at least three ticks per bit
`timescale 1ns/100ps
`include "acr_defines.svh"
module acr_sar_core
  import acr_pkg::*;
#(
  parameter int SAMPLE_TICKS = `ACR_SAMPLE_TK,
  parameter int BIT_TICKS    = `ACR_BIT_TK
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       comp,
  // trial code, sample strobe and results
  output logic [9:0]      trial,
  output logic            sample,
  output logic            done,
  output logic [9:0]      result
);
  localparam int TOTAL = SAMPLE_TICKS + `ACR_RES_BITS * BIT_TICKS;

  if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 15 || BIT_TICKS < 3 || BIT_TICKS > 15)
    $error("acr_sar_core: tick counts out of range");

  acr_core_t q, d;
  logic [7:0] hc_q;

  // trial code with the decided bit kept or dropped
  logic [9:0] keep;
  always_comb begin
    keep = comp ? q.trial : (q.trial & ~(10'h001 << q.bitn));
  end

  // one bit decided per BIT_TICKS ticks, restart at once when done
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (!run) begin
      d.phase  = ACR_IDLE;
      d.sample = 1'b0;
      d.trial  = `ACR_RES_RST;
      d.tk     = 4'h0;
    end else if (tick) begin
      case (q.phase)
        ACR_IDLE: begin
          d.phase  = ACR_SAMPLE;
          d.sample = 1'b1;
          d.tk     = 4'h0;
        end
        ACR_SAMPLE: begin
          if (q.tk == 4'(SAMPLE_TICKS - 1)) begin
            d.phase  = ACR_CONV;
            d.sample = 1'b0;
            d.tk     = 4'h0;
            d.bitn   = 4'h9;
            d.trial  = `ACR_RES_MSB;
            d.allhi  = 1'b1;
            d.alllo  = 1'b1;
          end else begin
            d.tk = q.tk + 4'h1;
          end
        end
        ACR_CONV: begin
          if (q.tk == 4'(BIT_TICKS - 1)) begin
            d.tk    = 4'h0;
            d.allhi = q.allhi & comp;
            d.alllo = q.alllo & ~comp;
            if (q.bitn == 4'h0) begin
              d.res    = keep; // result and done leave together
              d.done   = 1'b1;
              d.phase  = ACR_SAMPLE; // continuous conversion
              d.sample = 1'b1;
              d.trial  = `ACR_RES_RST;
            end else begin
              d.bitn  = q.bitn - 4'h1;
              d.trial = keep | (10'h001 << (q.bitn - 4'h1));
            end
          end else begin
            d.tk = q.tk + 4'h1;
          end
        end
        default: d.phase = ACR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else        q <= d;
  end

  // tick count since sampling began, read only by the checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)                          hc_q <= 8'h00;
    else if (!run)                       hc_q <= 8'h00;
    else if (tick && d.sample && !q.sample) hc_q <= 8'h00;
    else if (tick && d.done)             hc_q <= 8'h00;
    else if (tick)                       hc_q <= hc_q + 8'h01;
  end

  assign trial  = q.trial;
  assign sample = q.sample;
  assign done   = q.done;
  assign result = q.res;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  conv_length_a: assert property (done |-> $past(hc_q) == 8'(TOTAL - 1))
    else $error("conversion length wrong");
  full_scale_a: assert property (done && q.allhi |-> q.res == `ACR_RES_FULL)
    else $error("saturated input not full scale");
  zero_scale_a: assert property (done && q.alllo |-> q.res == `ACR_RES_RST)
    else $error("low input not zero");
  restart_a: assert property (done |-> q.phase == ACR_SAMPLE && q.sample)
    else $error("no restart after done");
  stop_off_a: assert property (!run |=> q.phase == ACR_IDLE && !done)
    else $error("sequencer running while off");
endmodule
